// File: tsi_pkg.sv
`default_nettype none
package tsi_pkg;
  localparam int CLK_NS          = 8;
  localparam int I2C_QUARTER_NS  = 2500;
  localparam int I2C_QUARTER_CYC = (I2C_QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYC          = MS_NS / CLK_NS;

  localparam logic [7:0] CH_WRITE   = 8'h77;
  localparam logic [7:0] CH_READ    = 8'h72;
  localparam logic [7:0] CH_COMMENT = 8'h23;
  localparam logic [7:0] CH_BREAK   = 8'h62;
  localparam logic [7:0] CH_DELAY   = 8'h64;
  localparam logic [7:0] CH_CR      = 8'h0D;

  localparam logic [5:0] SLV_PATTERN = 6'h24;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic       DIR_WRITE   = 1'b0;
  localparam int         CTRL_FLAG_BIT = 7;
  localparam logic [7:0] CTRL_RES10    = 8'h80;

  localparam int RD_FIRST_POS = 1;
  localparam int RD_CNT_POS   = 2;
  localparam int RD_STRIDE    = 3;
  localparam int WR_FIRST_POS = 1;
  localparam int WR_MIN_LEN   = 2;

  localparam logic [7:0] REG_X       = 8'h00;
  localparam logic [7:0] REG_Y       = 8'h08;
  localparam logic [7:0] REG_PRESS_A = 8'h10;
  localparam logic [7:0] REG_PRESS_B = 8'h18;
  localparam logic [7:0] REG_AUX     = 8'h20;
  localparam logic [7:0] REG_TEMP_A  = 8'h28;
  localparam logic [7:0] REG_TEMP_B  = 8'h30;

  localparam logic [2:0] FLD_X       = 3'h0;
  localparam logic [2:0] FLD_Y       = 3'h1;
  localparam logic [2:0] FLD_PRESS_A = 3'h2;
  localparam logic [2:0] FLD_PRESS_B = 3'h3;
  localparam logic [2:0] FLD_AUX     = 3'h4;
  localparam logic [2:0] FLD_TEMP_A  = 3'h5;
  localparam logic [2:0] FLD_TEMP_B  = 3'h6;
  localparam logic [2:0] FLD_NONE    = 3'h7;
  localparam int         NFIELD      = 7;
  localparam logic [15:0] NOT_UPDATED = 16'h270F;

  typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP} tsi_op_t;

  typedef struct packed {
    tsi_op_t    op;
    logic       rd;
    logic       nack;
    logic [7:0] data;
  } tsi_i2c_cmd_t;

  typedef struct packed {
    logic [7:0]  reg_addr;
    logic [15:0] data;
  } tsi_rd_word_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] first_pressure_reading;
    logic [15:0] second_pressure_reading;
    logic [15:0] aux;
    logic [15:0] first_temperature_reading;
    logic [15:0] second_temperature_reading;
  } tsi_log_row_t;
endpackage
`default_nettype wire

// File: tsi_tick.sv
`timescale 1ns/1ns
`default_nettype none
module tsi_tick #(
  parameter int DIV = 125000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= (cnt_r == CW'(DIV - 1));
      if (cnt_r == CW'(DIV - 1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tsi_i2c_eng.sv
`timescale 1ns/1ns
`default_nettype none
module tsi_i2c_eng
  import tsi_pkg::*;
#(
  parameter int QCYC = I2C_QUARTER_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         cmd_valid,
  input  wire tsi_i2c_cmd_t cmd,
  output logic              cmd_ready,
  output logic              done,
  output logic [7:0]        rdata,
  output logic              nack,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe_n,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_n
);
  typedef enum {E_IDLE, E_START, E_BITS, E_STOP} tsi_eng_st_t;
  tsi_eng_st_t st_r;
  logic [1:0]  q_r;
  logic [3:0]  bitn_r;
  logic [8:0]  tx_r;
  logic [8:0]  rx_r;
  logic        scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic        qtick;
  logic        adv;

  tsi_tick #(.DIV(QCYC)) u_qtick (.clk(clk), .rst_n(rst_n), .tick(qtick));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // A slave stretching the clock holds the quarter sequence
  assign adv = qtick && !(scl_oe_n && !scl_s_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= E_IDLE;
      q_r       <= 2'h0;
      bitn_r    <= 4'h0;
      tx_r      <= 9'h1FF;
      rx_r      <= 9'h000;
      cmd_ready <= 1'b1;
      done      <= 1'b0;
      rdata     <= 8'h00;
      nack      <= 1'b0;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
    end else begin
      done  <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      case (st_r)
        E_IDLE: if (cmd_valid && cmd_ready) begin
          cmd_ready <= 1'b0;
          q_r       <= 2'h0;
          bitn_r    <= 4'h0;
          tx_r      <= cmd.rd ? {8'hFF, cmd.nack} : {cmd.data, 1'b1};
          case (cmd.op)
            OP_START: st_r <= E_START;
            OP_BYTE:  st_r <= E_BITS;
            default:  st_r <= E_STOP;
          endcase
        end
        E_START: if (adv) begin
          q_r <= q_r + 1'b1;
          case (q_r)
            2'h0: sda_oe_n <= 1'b1;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b0;
            default: begin
              scl_oe_n  <= 1'b0;
              st_r      <= E_IDLE;
              done      <= 1'b1;
              cmd_ready <= 1'b1;
            end
          endcase
        end
        E_BITS: if (adv) begin
          q_r <= q_r + 1'b1;
          case (q_r)
            2'h0: sda_oe_n <= tx_r[8];
            2'h1: scl_oe_n <= 1'b1;
            2'h2: begin
              rx_r <= {rx_r[7:0], sda_s_r};
              tx_r <= {tx_r[7:0], 1'b1};
            end
            default: begin
              scl_oe_n <= 1'b0;
              if (bitn_r == 4'h8) begin
                rdata     <= rx_r[8:1];
                nack      <= rx_r[0];
                st_r      <= E_IDLE;
                done      <= 1'b1;
                cmd_ready <= 1'b1;
              end else begin
                bitn_r <= bitn_r + 1'b1;
              end
            end
          endcase
        end
        E_STOP: if (adv) begin
          q_r <= q_r + 1'b1;
          case (q_r)
            2'h0: sda_oe_n <= 1'b0;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b1;
            default: begin
              st_r      <= E_IDLE;
              done      <= 1'b1;
              cmd_ready <= 1'b1;
            end
          endcase
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end

  AST_SDA_STILL_IN_BIT: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == E_BITS && scl_oe_n && $past(scl_oe_n)) |-> $stable(sda_oe_n))
    else $error("data line moved while clock high in a bit");
  AST_STOP_RELEASES: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == E_STOP && adv && q_r == 2'h3) |=> (done && scl_oe_n && sda_oe_n && cmd_ready))
    else $error("stop did not leave both lines released");
endmodule
`default_nettype wire

// File: tsi_interp.sv
`timescale 1ns/1ns
`default_nettype none
module tsi_interp
  import tsi_pkg::*;
#(
  parameter int BUF_DEPTH = 16,
  parameter int MS_CYCLES = MS_CYC,
  parameter int QCYC      = I2C_QUARTER_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   in_valid,
  input  wire logic [7:0] in_char,
  output logic        in_ready,
  input  wire logic   resume,
  input  wire logic   restart,
  input  wire logic   log_start,
  input  wire logic   log_stop,
  input  wire logic   address_select_jumper,
  input  wire logic   scl_i,
  output logic        scl_o,
  output logic        scl_oe_n,
  input  wire logic   sda_i,
  output logic        sda_o,
  output logic        sda_oe_n,
  output logic        busy,
  output logic        halted,
  output logic        nack_err,
  output logic        res10,
  output logic        rd_valid,
  output tsi_rd_word_t rd_word,
  output logic        row_valid,
  output tsi_log_row_t row
);
  localparam int IW = $clog2(BUF_DEPTH);
  localparam int LW = IW + 1;

  typedef enum {S_RX, S_EXEC, S_START1, S_ADDR1, S_DATA, S_START2, S_ADDR2,
                S_RD_HI, S_RD_LO, S_STOP, S_DELAY, S_BREAK, S_END} tsi_st_t;

  function automatic logic [4:0] hexd(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hexd = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      hexd = {1'b1, c[3:0] + 4'h9};
    else hexd = 5'h00;
  endfunction

  function automatic logic [2:0] field_of(input logic [7:0] r);
    case (r)
      REG_X:       field_of = FLD_X;
      REG_Y:       field_of = FLD_Y;
      REG_PRESS_A: field_of = FLD_PRESS_A;
      REG_PRESS_B: field_of = FLD_PRESS_B;
      REG_AUX:     field_of = FLD_AUX;
      REG_TEMP_A:  field_of = FLD_TEMP_A;
      REG_TEMP_B:  field_of = FLD_TEMP_B;
      default:     field_of = FLD_NONE;
    endcase
  endfunction

  tsi_st_t      st_r;
  logic [7:0]   buf_r [BUF_DEPTH];
  logic [LW-1:0] len_r, ptr_r;
  logic [7:0]   cmd_ch_r, rd_left_r, hi_byte_r;
  logic [3:0]   hi_r;
  logic         half_r, first_r, sent_r, fail_r, in_ready_r, busy_r, halted_r;
  logic         nack_err_r, res10_r, rd_valid_r, row_valid_r, log_on_r;
  logic         touch_seen_r, any_seen_r;
  logic         sel_m_r, slave_address_select_bit;
  logic [15:0]  dly_r;
  logic [31:0]  stamp_r;
  logic [15:0]  meas_r [NFIELD];
  tsi_rd_word_t rd_word_r;
  tsi_log_row_t row_r;
  tsi_i2c_cmd_t cmd_r, ncmd;
  logic         cmd_v_r, i2c_rdy, i2c_done, i2c_nack, ms_tick;
  logic [7:0]   i2c_rdata;
  logic [4:0]   hx;
  logic [7:0]   cur_byte;
  logic         is_bus, is_read, ctrl_only;

  assign hx        = hexd(in_char);
  assign cur_byte  = buf_r[ptr_r[IW-1:0]];
  assign is_read   = (cmd_ch_r == CH_READ);
  assign ctrl_only = !is_read && ptr_r == LW'(WR_FIRST_POS) && cur_byte[CTRL_FLAG_BIT];
  assign is_bus    = st_r inside {S_START1, S_ADDR1, S_DATA, S_START2, S_ADDR2,
                                  S_RD_HI, S_RD_LO, S_STOP};
  assign in_ready  = in_ready_r;
  assign busy      = busy_r;
  assign halted    = halted_r;
  assign nack_err  = nack_err_r;
  assign res10     = res10_r;
  assign rd_valid  = rd_valid_r;
  assign rd_word   = rd_word_r;
  assign row_valid = row_valid_r;
  assign row       = row_r;

  tsi_tick #(.DIV(MS_CYCLES)) u_ms (.clk(clk), .rst_n(rst_n), .tick(ms_tick));

  tsi_i2c_eng #(.QCYC(QCYC)) u_eng (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_v_r), .cmd(cmd_r), .cmd_ready(i2c_rdy),
    .done(i2c_done), .rdata(i2c_rdata), .nack(i2c_nack),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

  // Jumper is a board pin, so it is synchronised before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_m_r                  <= 1'b0;
      slave_address_select_bit <= 1'b0;
    end else begin
      sel_m_r                  <= address_select_jumper;
      slave_address_select_bit <= sel_m_r;
    end
  end

  always_comb begin
    ncmd = '{op: OP_BYTE, rd: 1'b0, nack: 1'b0, data: cur_byte};
    case (st_r)
      S_START1, S_START2: ncmd.op = OP_START;
      S_ADDR1: ncmd.data = {SLV_PATTERN, slave_address_select_bit, DIR_WRITE};
      S_ADDR2: ncmd.data = {SLV_PATTERN, slave_address_select_bit, DIR_READ};
      S_RD_HI: ncmd.rd = 1'b1;
      S_RD_LO: begin
        ncmd.rd   = 1'b1;
        ncmd.nack = 1'b1;
      end
      S_STOP:  ncmd.op = OP_STOP;
      default: ncmd.op = OP_BYTE;
    endcase
  end

  // One engine request per bus state (one per byte in S_DATA), held until the engine takes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_v_r <= 1'b0;
      cmd_r   <= '0;
      sent_r  <= 1'b0;
    end else if (cmd_v_r) begin
      if (i2c_rdy) cmd_v_r <= 1'b0;
    end else if (i2c_done) begin
      sent_r <= 1'b0;
    end else if (is_bus && !sent_r) begin
      cmd_v_r <= 1'b1;
      cmd_r   <= ncmd;
      sent_r  <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_RX;
      for (int i = 0; i < BUF_DEPTH; i++) buf_r[i] <= 8'h00;
      len_r <= '0; ptr_r <= '0; cmd_ch_r <= 8'h00; hi_r <= 4'h0;
      half_r <= 1'b0; first_r <= 1'b1; fail_r <= 1'b0; in_ready_r <= 1'b1;
      busy_r <= 1'b0; halted_r <= 1'b0; nack_err_r <= 1'b0; rd_valid_r <= 1'b0;
      rd_left_r <= 8'h00; hi_byte_r <= 8'h00; dly_r <= 16'h0000; rd_word_r <= '0;
    end else begin
      nack_err_r <= 1'b0;
      rd_valid_r <= 1'b0;
      case (st_r)
        S_RX: if (in_valid && in_ready_r) begin
          if (in_char == CH_CR) begin
            if (!first_r) begin
              in_ready_r <= 1'b0;
              busy_r     <= 1'b1;
              st_r       <= S_EXEC;
            end
          end else if (first_r) begin
            cmd_ch_r <= in_char;
            first_r  <= 1'b0;
          end else if (hx[4]) begin
            if (half_r) begin
              // Bytes past the buffer depth are dropped
              if (len_r < LW'(BUF_DEPTH)) begin
                buf_r[len_r[IW-1:0]] <= {hi_r, hx[3:0]};
                len_r <= len_r + 1'b1;
              end
            end else begin
              hi_r <= hx[3:0];
            end
            half_r <= !half_r;
          end
        end
        S_EXEC: begin
          ptr_r     <= LW'(RD_FIRST_POS);
          rd_left_r <= buf_r[RD_CNT_POS];
          fail_r    <= 1'b0;
          case (cmd_ch_r)
            CH_WRITE: st_r <= (len_r >= LW'(WR_MIN_LEN)) ? S_START1 : S_END;
            CH_READ:  st_r <= (len_r > LW'(RD_CNT_POS) && buf_r[RD_CNT_POS] != 8'h00) ?
                              S_START1 : S_END;
            CH_DELAY: begin
              dly_r <= (len_r == '0) ? 16'h0000 :
                       (len_r == LW'(1)) ? {8'h00, buf_r[0]} : {buf_r[0], buf_r[1]};
              st_r  <= S_DELAY;
            end
            CH_BREAK: begin
              halted_r <= 1'b1;
              st_r     <= S_BREAK;
            end
            default:  st_r <= S_END;
          endcase
        end
        S_START1: if (i2c_done) st_r <= S_ADDR1;
        S_ADDR1, S_ADDR2, S_DATA: if (i2c_done) begin
          if (i2c_nack) begin
            nack_err_r <= 1'b1;
            fail_r     <= 1'b1;
            st_r       <= S_STOP;
          end else if (st_r == S_ADDR1) begin
            st_r <= S_DATA;
          end else if (st_r == S_ADDR2) begin
            st_r <= S_RD_HI;
          end else if (is_read) begin
            st_r <= S_START2;
          end else if (ctrl_only || ptr_r + 1'b1 >= len_r) begin
            st_r <= S_STOP;
          end else begin
            ptr_r <= ptr_r + 1'b1;
          end
        end
        S_START2: if (i2c_done) st_r <= S_ADDR2;
        S_RD_HI: if (i2c_done) begin
          hi_byte_r <= i2c_rdata;
          st_r      <= S_RD_LO;
        end
        S_RD_LO: if (i2c_done) begin
          rd_word_r  <= '{reg_addr: cur_byte, data: {hi_byte_r, i2c_rdata}};
          rd_valid_r <= 1'b1;
          ptr_r      <= ptr_r + LW'(RD_STRIDE);
          rd_left_r  <= rd_left_r - 1'b1;
          st_r       <= S_STOP;
        end
        S_STOP: if (i2c_done) begin
          // Next register only after this transfer's stop has gone out
          st_r <= (is_read && !fail_r && rd_left_r != 8'h00 && ptr_r < len_r) ?
                  S_START1 : S_END;
        end
        S_DELAY: if (ms_tick) begin
          // One tick more than the count, since the first one is partial
          if (dly_r == 16'h0000) st_r <= S_END;
          else dly_r <= dly_r - 1'b1;
        end
        S_BREAK: if (resume || restart) begin
          halted_r <= 1'b0;
          st_r     <= S_END;
        end
        S_END: begin
          in_ready_r <= 1'b1;
          busy_r     <= 1'b0;
          first_r    <= 1'b1;
          half_r     <= 1'b0;
          len_r      <= '0;
          st_r       <= S_RX;
        end
        default: st_r <= S_END;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res10_r <= 1'b0;
    end else if (st_r == S_DATA && i2c_done && !i2c_nack && ctrl_only) begin
      res10_r <= (cur_byte == CTRL_RES10);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stamp_r <= 32'h0000_0000;
    else if (ms_tick) stamp_r <= stamp_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      log_on_r     <= 1'b0;
      touch_seen_r <= 1'b0;
      any_seen_r   <= 1'b0;
      row_valid_r  <= 1'b0;
      row_r        <= '0;
      for (int i = 0; i < NFIELD; i++) meas_r[i] <= NOT_UPDATED;
    end else begin
      if (log_stop) log_on_r <= 1'b0;
      else if (log_start) log_on_r <= 1'b1;
      if (st_r == S_EXEC || restart) begin
        touch_seen_r <= 1'b0;
        any_seen_r   <= 1'b0;
      end else if (st_r == S_RD_LO && i2c_done && field_of(cur_byte) != FLD_NONE) begin
        meas_r[field_of(cur_byte)] <= {hi_byte_r, i2c_rdata};
        any_seen_r <= 1'b1;
        if (field_of(cur_byte) <= FLD_PRESS_B) touch_seen_r <= 1'b1;
      end
      row_valid_r <= (st_r == S_END) && log_on_r && any_seen_r;
      if (st_r == S_END) begin
        row_r.stamp <= stamp_r;
        row_r.x <= touch_seen_r ? meas_r[FLD_X] : NOT_UPDATED;
        row_r.y <= touch_seen_r ? meas_r[FLD_Y] : NOT_UPDATED;
        row_r.first_pressure_reading  <= touch_seen_r ? meas_r[FLD_PRESS_A] : NOT_UPDATED;
        row_r.second_pressure_reading <= touch_seen_r ? meas_r[FLD_PRESS_B] : NOT_UPDATED;
        row_r.aux <= touch_seen_r ? NOT_UPDATED : meas_r[FLD_AUX];
        row_r.first_temperature_reading  <= touch_seen_r ? NOT_UPDATED : meas_r[FLD_TEMP_A];
        row_r.second_temperature_reading <= touch_seen_r ? NOT_UPDATED : meas_r[FLD_TEMP_B];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_CR_ENDS_LINE: assert property (
    (st_r == S_RX && in_valid && in_ready_r && in_char == CH_CR && !first_r)
      |=> (st_r == S_EXEC && !in_ready_r))
    else $error("carriage return did not start execution");
  AST_SLAVE_ADDR: assert property (
    (cmd_v_r && st_r inside {S_ADDR1, S_ADDR2}) |-> (cmd_r.data[7:2] == SLV_PATTERN &&
      cmd_r.data[0] == (st_r == S_ADDR2) && cmd_r.data[1] == slave_address_select_bit))
    else $error("slave address byte malformed");
  AST_BREAK_ENTRY: assert property (
    (st_r == S_EXEC && cmd_ch_r == CH_BREAK) |=> (st_r == S_BREAK && halted_r))
    else $error("break line did not halt");
  AST_BREAK_HOLDS: assert property (
    (st_r == S_BREAK && !resume && !restart) |=> (st_r == S_BREAK && !in_ready_r))
    else $error("halt left without resume or restart");
  AST_CTRL_ALONE: assert property (
    (st_r == S_DATA && i2c_done && !i2c_nack && ctrl_only) |=> st_r == S_STOP)
    else $error("control byte write continued");
  AST_NACK_FLAG: assert property (
    (i2c_done && i2c_nack && st_r inside {S_ADDR1, S_ADDR2, S_DATA})
      |=> (nack_err_r && st_r == S_STOP) ##1 !nack_err_r)
    else $error("missing acknowledge not flagged or not stopped");
  AST_DELAY_WAITS: assert property (
    (st_r == S_DELAY && !ms_tick) |=> st_r == S_DELAY)
    else $error("delay ended without a millisecond tick");
  AST_ROW_FILL: assert property (
    (row_valid_r && row_r.x != NOT_UPDATED) |-> (row_r.aux == NOT_UPDATED &&
      row_r.first_temperature_reading == NOT_UPDATED &&
      row_r.second_temperature_reading == NOT_UPDATED))
    else $error("touched row carries other readings");
  AST_LOG_STOPPED: assert property (
    log_stop |=> (!log_on_r ##1 !row_valid_r))
    else $error("row produced after stop request");
endmodule
`default_nettype wire

// File: tsi_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsi_slave_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sel,
  output logic      sda_oe_n
);
  logic [7:0] sh, rp, tx;
  int         bc, nb;
  bit         act, rd, first, nk;
  logic [7:0] got[$];
  initial sda_oe_n = 1'b1;
  always @(negedge sda) if (scl) begin
    // The start's own falling clock edge carries no bit
    act = 1; bc = -1; first = 1; nk = 0; rd = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 0; sda_oe_n = 1'b1;
  end
  always @(posedge scl) if (act) begin
    if (bc < 8) sh = {sh[6:0], sda};
    else if (rd && sda) nk = 1;
  end
  // Read data: high byte is the register address, low byte its inverse
  always @(negedge scl) if (act) begin
    if (bc == 8) begin
      bc = 0;
      tx = nb ? ~rp : rp;
      sda_oe_n = (rd && !nk) ? tx[7] : 1'b1;
      if (rd) nb++;
    end else begin
      bc++;
      if (bc < 8) begin
        if (rd) sda_oe_n = tx[7-bc];
      end else if (first) begin
        first = 0;
        // Only our own address is acknowledged; any other frame is ignored
        if (sh[7:1] == {6'h24, sel}) begin sda_oe_n = 0; rd = sh[0]; nb = 0; end
        else act = 0;
      end else if (rd) sda_oe_n = 1'b1;
      else begin
        if (nb == 0) rp = sh;
        got.push_back(sh);
        nb++;
        sda_oe_n = 0;
      end
    end
  end
endmodule
`default_nettype wire

// File: touch_script_i2c_interpreter_test.sv
`timescale 1ns/1ns
`default_nettype none
module touch_script_i2c_interpreter_test;
  import tsi_pkg::*;
  logic         clk, rst_n, in_valid, resume, restart, log_start, log_stop, jmp;
  logic         scl_o, sda_o;
  logic [7:0]   in_char;
  logic         in_ready, scl_oe_n, sda_oe_n, s_oe_n, busy, halted, nack_err, res10;
  logic         rd_valid, row_valid;
  tsi_rd_word_t rd_word;
  tsi_log_row_t row;
  wire logic    scl = scl_oe_n;
  wire logic    sda = sda_oe_n & s_oe_n;
  int           errors, checked, nerr, cyc, n;
  tsi_rd_word_t rq[$];
  tsi_log_row_t wq[$];
  tsi_interp #(.MS_CYCLES(20), .QCYC(4)) u_tsi_interp (.clk, .rst_n, .in_valid, .in_char,
    .in_ready, .resume, .restart, .log_start, .log_stop, .address_select_jumper(jmp),
    .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .busy, .halted,
    .nack_err, .res10, .rd_valid, .rd_word, .row_valid, .row);
  tsi_slave_model u_tsi_slave_model (.scl, .sda, .sel(1'b0), .sda_oe_n(s_oe_n));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_valid) rq.push_back(rd_word);
    if (row_valid) wq.push_back(row);
    if (nack_err) nerr++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic send(input string s);
    foreach (s[i]) begin
      in_char <= s[i];
      in_valid <= 1;
      @(posedge clk);
      for (cyc = 0; !in_ready && cyc < 20000; cyc++) @(posedge clk);
      if (cyc == 20000) begin
        errors++;
        end_sim();
      end
    end
    in_valid <= 0;
  endtask
  task automatic idle;
    repeat (2) @(posedge clk);
    for (cyc = 0; busy && cyc < 20000; cyc++) @(posedge clk);
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic line(input string s);
    send(s);
    idle();
  endtask
  task automatic t_basic;
    logic [7:0] g[$];
    n = u_tsi_slave_model.got.size();
    line("#\r");
    chk(u_tsi_slave_model.got.size(), n);
    line("w 90 80\r");
    chk(u_tsi_slave_model.got.size(), n + 1);
    chk(u_tsi_slave_model.got[n], 8'h80);
    chk(res10, 1'b1);
    line("w 90 60 A9 24\r");
    chk({u_tsi_slave_model.got[n+1], u_tsi_slave_model.got[n+2]}, 16'h60A9);
    chk(u_tsi_slave_model.got[n+3], 8'h24);
    n = u_tsi_slave_model.got.size();
    line("w 90 40 0F F0 48 00 0F 50 0F F0 58 00 0F\r");
    g = u_tsi_slave_model.got;
    chk(g.size(), n + 12);
    chk({g[n], g[n+3], g[n+6], g[n+9]}, 32'h40485058);
    chk({g[n+1], g[n+2], g[n+10], g[n+11]}, 32'h0FF0000F);
    line("r 91 38 01 00\r");
    chk(rq.pop_back(), 24'h3838C7);
    line("d 03\r");
    chk(cyc >= 60 && cyc <= 90, 1);
  endtask
  task automatic t_log;
    rq.delete();
    log_start <= 1;
    @(posedge clk);
    log_start <= 0;
    line("r 91 00 04 00 08 00 00 10 00 00 18 00 00\r");
    chk(rq.size(), 4);
    for (int i = 0; i < 4; i++) chk(rq[i], {i[4:0], 3'h0, i[4:0], 3'h0, ~i[4:0], 3'h7});
    chk({wq[0].x, wq[0].second_pressure_reading}, 32'h00FF18E7);
    chk({wq[0].y, wq[0].aux}, 32'h08F7270F);
    line("r 91 20 01 00\r");
    chk({wq[1].x, wq[1].aux}, 32'h270F20DF);
    chk(wq[1].stamp > wq[0].stamp, 1);
    log_stop <= 1;
    @(posedge clk);
    log_stop <= 0;
    line("r 91 20 01 00\r");
    chk(wq.size(), 2);
  endtask
  task automatic t_halt;
    for (int k = 0; k < 2; k++) begin
      send("b\r");
      repeat (10) @(posedge clk);
      chk(halted, 1'b1);
      if (k == 0) resume <= 1;
      else restart <= 1;
      @(posedge clk);
      resume <= 0;
      restart <= 0;
      idle();
      chk(halted, 1'b0);
    end
    jmp <= 1;
    line("w 90 60 00 00\r");
    chk(nerr, 1);
  endtask
  initial begin
    {rst_n, in_valid, in_char, resume, restart, log_start, log_stop, jmp} = '0;
    repeat (3) @(posedge clk);
    chk({in_ready, busy, halted, scl_oe_n, sda_oe_n, res10, scl_o, sda_o}, 8'h98);
    rst_n <= 1;
    @(posedge clk);
    t_basic();
    t_log();
    t_halt();
    end_sim();
  end
endmodule
`default_nettype wire
